// *** cms_status_flags.sv ***
// communication/memory status and first-to-alert latched flag bank
`timescale 1ns/1ps
module cms_status_flags
    import cms_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // register port from the bus command decoder
    input  wire logic [7:0] reg_cmd,
    input  wire logic       reg_wr,
    input  wire logic [1:0] reg_wlen,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic            reg_claim,
    output logic [7:0]      reg_rdata,
    output logic            reg_rvalid,
    // communication events, one-cycle pulses
    input  wire logic       bad_command_evt,
    input  wire logic       bad_data_evt,
    input  wire logic       pec_fail_evt,
    input  wire logic       other_comm_evt,
    // memory events, one-cycle pulses except the boot qualifiers
    input  wire logic       store_parity_fail,
    input  wire logic       restore_parity_fail,
    input  wire logic       nvm_prog_fail,
    input  wire logic       boot_restore_done,
    input  wire logic       boot_mismatch,
    input  wire logic       boot_parity_fail,
    input  wire logic       mem_update_done,
    // non-volatile backup of the comm register
    input  wire logic       nvm_restore_load,
    input  wire logic [7:0] nvm_restore_data,
    output logic [7:0]      nvm_comm_image,
    // output turn-on through the on/off configuration
    input  wire logic       output_on_evt,
    // alert line
    input  wire logic       alert_assert,
    input  wire logic       smbalert_line_in,
    output logic            comm_alert_req,
    // summary bits toward the status byte
    output logic            comm_summary,
    output logic            other_summary
);

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    wire hit_comm     = (reg_cmd == CMD_COMM_STATUS);
    wire hit_first    = (reg_cmd == CMD_FIRST_ALERT);
    wire hit_clear    = (reg_cmd == CMD_CLEAR_FAULTS);
    wire len_is_byte  = (reg_wlen == LEN_WRITE_BYTE);
    wire len_is_send  = (reg_wlen == LEN_SEND_BYTE);

    // a write to either register must carry exactly one byte
    wire wr_comm_ok   = reg_wr & hit_comm & len_is_byte;
    wire wr_first_ok  = reg_wr & hit_first & len_is_byte;
    wire wr_bad_len   = reg_wr & (hit_comm | hit_first) & ~len_is_byte;
    wire clear_faults = reg_wr & hit_clear & len_is_send;

    assign reg_claim = hit_comm | hit_first;

    ////////////////////////////////////////////////////////////////////////////
    // register images

    logic [NUM_FLAGS-1:0] flag_q;
    logic [7:0]           comm_value;
    logic [7:0]           first_value;

    // unsupported positions tied to zero
    always_comb begin
        comm_value = COMM_STATUS_RESET;
        comm_value[POS_BAD_CMD]    = flag_q[IDX_BAD_CMD];
        comm_value[POS_BAD_DATA]   = flag_q[IDX_BAD_DATA];
        comm_value[POS_PEC_FAIL]   = flag_q[IDX_PEC];
        comm_value[POS_MEM_ERR]    = flag_q[IDX_MEM];
        comm_value[POS_OTHER_COMM] = flag_q[IDX_OTHER];
    end

    always_comb begin
        first_value = FIRST_ALERT_RESET;
        first_value[POS_FIRST_ALERT] = flag_q[IDX_FIRST];
    end

    ////////////////////////////////////////////////////////////////////////////
    // clear requests

    // write-one-to-clear, masked to supported bits so zeros and read-only
    // positions are inert
    wire [7:0] comm_w1c  = wr_comm_ok  ? (reg_wdata & COMM_STATUS_MASK) : 8'h00;
    wire [7:0] first_w1c = wr_first_ok ? (reg_wdata & FIRST_ALERT_MASK) : 8'h00;

    wire clear_all = clear_faults | output_on_evt;

    logic [NUM_FLAGS-1:0] clr_vec;

    always_comb begin
        clr_vec[IDX_BAD_CMD]  = clear_all | comm_w1c[POS_BAD_CMD];
        clr_vec[IDX_BAD_DATA] = clear_all | comm_w1c[POS_BAD_DATA];
        clr_vec[IDX_PEC]      = clear_all | comm_w1c[POS_PEC_FAIL];
        clr_vec[IDX_MEM]      = clear_all | comm_w1c[POS_MEM_ERR];
        clr_vec[IDX_OTHER]    = clear_all | comm_w1c[POS_OTHER_COMM];
        clr_vec[IDX_FIRST]    = clear_all | first_w1c[POS_FIRST_ALERT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory error sources and lock

    wire boot_fail = boot_restore_done & (boot_mismatch | boot_parity_fail);

    // a restored image carrying the memory bit is treated as a fresh error
    wire nvm_mem_bit = nvm_restore_load & nvm_restore_data[POS_MEM_ERR];

    wire mem_err = store_parity_fail | restore_parity_fail | nvm_prog_fail
                 | boot_fail | nvm_mem_bit;

    cms_mem_state_t mem_state;
    cms_mem_state_t next_mem_state;

    always_comb begin
        next_mem_state = mem_state;
        unique case (mem_state)
            MEM_CLEAN: begin
                if (mem_err) begin
                    next_mem_state = MEM_LOCKED;
                end
            end
            MEM_LOCKED: begin
                // a new error in the same cycle as the update keeps the lock
                if (mem_update_done && !mem_err) begin
                    next_mem_state = MEM_UPDATED;
                end
            end
            MEM_UPDATED: begin
                if (mem_err) begin
                    next_mem_state = MEM_LOCKED;
                end else if (!flag_q[IDX_MEM]) begin
                    next_mem_state = MEM_CLEAN;
                end
            end
            default: begin
                next_mem_state = MEM_LOCKED;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_state <= MEM_CLEAN;
        end else begin
            mem_state <= next_mem_state;
        end
    end

    // clears of the memory bit are blocked until the memory is rewritten
    wire mem_hold = (mem_state != MEM_UPDATED);

    ////////////////////////////////////////////////////////////////////////////
    // first-to-alert capture

    logic alert_line_sync;
    logic alert_assert_q;

    cms_sync2 u_alert_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (smbalert_line_in),
        .sync_out (alert_line_sync)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_assert_q <= 1'b0;
        end else begin
            alert_assert_q <= alert_assert;
        end
    end

    // synced line lags our own drive by two cycles, so at the assert edge
    // a low level can only have come from another device
    wire alert_rise  = alert_assert & ~alert_assert_q;
    wire first_alert = alert_rise & alert_line_sync;

    ////////////////////////////////////////////////////////////////////////////
    // set events

    logic [NUM_FLAGS-1:0] set_vec;
    logic [NUM_FLAGS-1:0] hold_vec;

    // restored comm bits reload the latched state after power-up
    wire [7:0] nvm_set = nvm_restore_load ? (nvm_restore_data & COMM_STATUS_MASK) : 8'h00;

    always_comb begin
        set_vec[IDX_BAD_CMD]  = bad_command_evt | nvm_set[POS_BAD_CMD];
        set_vec[IDX_BAD_DATA] = bad_data_evt | wr_bad_len | nvm_set[POS_BAD_DATA];
        set_vec[IDX_PEC]      = pec_fail_evt | nvm_set[POS_PEC_FAIL];
        set_vec[IDX_MEM]      = mem_err;
        set_vec[IDX_OTHER]    = other_comm_evt | nvm_set[POS_OTHER_COMM];
        set_vec[IDX_FIRST]    = first_alert;
    end

    always_comb begin
        hold_vec = '0;
        hold_vec[IDX_MEM] = mem_hold;
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag cells

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi = gi + 1) begin : g_flag
            cms_flag u_flag (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .set_evt  (set_vec[gi]),
                .clr_req  (clr_vec[gi]),
                .hold     (hold_vec[gi]),
                .flag     (flag_q[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [7:0] next_rdata;
    logic       next_rvalid;

    // exactly one byte returned per read of either register
    assign next_rvalid = reg_rd & reg_claim;
    assign next_rdata  = hit_comm  ? (comm_value & COMM_STATUS_MASK) :
                         hit_first ? (first_value & FIRST_ALERT_MASK) :
                         RDATA_RESET;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= RDATA_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= next_rvalid;
            if (next_rvalid) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // summary, alert request and backup image

    // combinational OR of flops so the summary falls in the same cycle
    // as the individual clear takes effect
    assign comm_summary  = |(comm_value & COMM_STATUS_MASK);
    assign other_summary = |(first_value & FIRST_ALERT_MASK);

    // only comm flags ask for an alert; the first alerter bit is excluded
    assign comm_alert_req = comm_summary;

    // first-to-alert register deliberately absent from the backup image
    assign nvm_comm_image = comm_value & COMM_STATUS_MASK;

endmodule

// *** cms_pkg.sv ***
// constants and types shared by the communication/memory status flag bank
package cms_pkg;

    // command codes seen on the register port
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
    localparam logic [7:0] CMD_STATUS_BYTE   = 8'h78;
    localparam logic [7:0] CMD_COMM_STATUS   = 8'h7e;
    localparam logic [7:0] CMD_FIRST_ALERT   = 8'h7f;

    // data byte counts of the transactions
    localparam logic [1:0] LEN_SEND_BYTE  = 2'h0;
    localparam logic [1:0] LEN_WRITE_BYTE = 2'h1;

    // field positions, communication status register
    localparam int unsigned POS_BAD_CMD    = 7;
    localparam int unsigned POS_BAD_DATA   = 6;
    localparam int unsigned POS_PEC_FAIL   = 5;
    localparam int unsigned POS_MEM_ERR    = 4;
    localparam int unsigned POS_OTHER_COMM = 1;

    // field position, first-to-alert register
    localparam int unsigned POS_FIRST_ALERT = 0;

    // supported-bit masks, everything else reads zero
    localparam logic [7:0] COMM_STATUS_MASK = 8'hf2;
    localparam logic [7:0] FIRST_ALERT_MASK = 8'h01;

    // reset values
    localparam logic [7:0] COMM_STATUS_RESET = 8'h00;
    localparam logic [7:0] FIRST_ALERT_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET       = 8'h00;

    // flag cell indices
    localparam int unsigned NUM_FLAGS    = 6;
    localparam int unsigned IDX_BAD_CMD  = 0;
    localparam int unsigned IDX_BAD_DATA = 1;
    localparam int unsigned IDX_PEC      = 2;
    localparam int unsigned IDX_MEM      = 3;
    localparam int unsigned IDX_OTHER    = 4;
    localparam int unsigned IDX_FIRST    = 5;

    // idle level of the shared alert line
    localparam logic ALERT_LINE_IDLE = 1'b1;

    // memory error lock, gray along clean -> locked -> updated
    typedef enum logic [1:0] {
        MEM_CLEAN   = 2'h0,
        MEM_LOCKED  = 2'h1,
        MEM_UPDATED = 2'h3
    } cms_mem_state_t;

endpackage

// *** cms_sync2.sv ***
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module cms_sync2
    import cms_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // level
    input  wire logic async_in,
    output logic      sync_out
);

    logic stage1;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= ALERT_LINE_IDLE;
            sync_out <= ALERT_LINE_IDLE;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// *** cms_flag.sv ***
// one latched status flag: set wins over clear, hold blocks clear
`timescale 1ns/1ps
module cms_flag (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // control
    input  wire logic set_evt,
    input  wire logic clr_req,
    input  wire logic hold,
    // state
    output logic      flag
);

    logic next_flag;

    assign next_flag = set_evt | (flag & ~(clr_req & ~hold));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule

// *** cms_status_flags_monitor.sv ***
// concurrent checks on the status flag bank ports
`timescale 1ns/1ps
module cms_status_flags_monitor (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] reg_cmd,
    input wire logic       reg_wr,
    input wire logic [1:0] reg_wlen,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic       reg_claim,
    input wire logic       reg_rvalid,
    // events
    input wire logic       bad_command_evt,
    input wire logic       bad_data_evt,
    input wire logic       pec_fail_evt,
    input wire logic       other_comm_evt,
    input wire logic       store_parity_fail,
    input wire logic       restore_parity_fail,
    input wire logic       nvm_prog_fail,
    input wire logic       nvm_restore_load,
    input wire logic       alert_assert,
    // status
    input wire logic [7:0] nvm_comm_image,
    input wire logic       comm_alert_req,
    input wire logic       comm_summary,
    input wire logic       other_summary
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // a set in the same cycle beats a clear, so only quiet cycles are judged
    wire logic quiet = !(bad_command_evt | bad_data_evt | pec_fail_evt | other_comm_evt
        | nvm_restore_load);

    sequence s_read;
        reg_rd && reg_claim;
    endsequence
    sequence s_clear;
        reg_wr && reg_cmd == 8'h03 && reg_wlen == 2'h0;
    endsequence
    sequence s_w1c_top;
        reg_wr && reg_cmd == 8'h7e && reg_wlen == 2'h1 && reg_wdata[7];
    endsequence

    chk_read_answer: assert property (s_read |=> reg_rvalid)
        else $error("claimed read not answered");
    chk_no_stray_rvalid: assert property (reg_rvalid |-> $past(reg_rd && reg_claim))
        else $error("read answer without request");
    chk_claim_decode: assert property (reg_claim == (reg_cmd == 8'h7e || reg_cmd == 8'h7f))
        else $error("claim decode wrong");
    chk_bad_cmd_set: assert property (bad_command_evt |=> nvm_comm_image[7])
        else $error("bad command flag not set");
    chk_bad_data_set: assert property (bad_data_evt |=> nvm_comm_image[6])
        else $error("bad data flag not set");
    chk_pec_set: assert property (pec_fail_evt |=> nvm_comm_image[5])
        else $error("pec flag not set");
    chk_mem_set: assert property ((store_parity_fail | restore_parity_fail | nvm_prog_fail)
        |=> nvm_comm_image[4])
        else $error("memory flag not set");
    chk_other_set: assert property (other_comm_evt |=> nvm_comm_image[1])
        else $error("other comm flag not set");
    chk_unused_zero: assert property ((nvm_comm_image & 8'h0d) == 8'h00)
        else $error("unsupported bit set");
    chk_summary_or: assert property (comm_summary == |(nvm_comm_image & 8'hf2))
        else $error("summary not or of flags");
    chk_alert_req_src: assert property (comm_alert_req == comm_summary)
        else $error("alert request from wrong source");
    chk_clear_all: assert property (s_clear ##0 (quiet && !$rose(alert_assert))
        |=> (nvm_comm_image & 8'he2) == 8'h00 && !other_summary)
        else $error("clear faults left a flag");
    chk_w1c_top: assert property (s_w1c_top ##0 quiet |=> !nvm_comm_image[7])
        else $error("write one did not clear");
    chk_first_cause: assert property ($rose(other_summary)
        |-> $past(alert_assert) && !$past(alert_assert, 2))
        else $error("first alerter set without own rise");
endmodule

// *** cms_host_model.sv ***
// host stand-in driving the register port of the flag bank
`timescale 1ns/1ps
module cms_host_model (
    // clock
    input  wire logic       core_clk,
    // register port
    output logic [7:0]      reg_cmd,
    output logic            reg_wr,
    output logic [1:0]      reg_wlen,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_cmd = 8'h00;
        reg_wr = 1'b0;
        reg_wlen = 2'h0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // one byte per transaction; stale data inverted so it is never reused
    task automatic wr(input logic [7:0] cmd, input logic [1:0] len, input logic [7:0] d);
        @(negedge core_clk);
        reg_cmd = cmd;
        reg_wlen = len;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // answer is taken one cycle after the request edge
    task automatic rd(input logic [7:0] cmd, output logic [7:0] d, output logic v);
        @(negedge core_clk);
        reg_cmd = cmd;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        v = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

// *** tb_cms_status_flags.sv ***
// self-checking bench for the status flag bank
`timescale 1ns/1ps
module tb_cms_status_flags
    import cms_pkg::*;
;
    logic        core_clk;
    logic        rst_n;
    logic [7:0]  reg_cmd;
    logic        reg_wr;
    logic [1:0]  reg_wlen;
    logic [7:0]  reg_wdata;
    logic        reg_rd;
    logic        reg_claim;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [10:0] ev;
    logic        boot_mismatch;
    logic        boot_parity_fail;
    logic [7:0]  nvm_restore_data;
    logic [7:0]  nvm_comm_image;
    logic        alert_assert;
    logic        smbalert_line_in;
    logic        comm_alert_req;
    logic        comm_summary;
    logic        other_summary;
    int          mismatches;
    int          cmp_count;
    int          cyc = 0;

    cms_status_flags i_dut (.core_clk, .rst_n, .reg_cmd, .reg_wr, .reg_wlen, .reg_wdata,
        .reg_rd, .reg_claim, .reg_rdata, .reg_rvalid, .bad_command_evt(ev[0]),
        .bad_data_evt(ev[1]), .pec_fail_evt(ev[2]), .other_comm_evt(ev[3]),
        .store_parity_fail(ev[4]), .restore_parity_fail(ev[5]), .nvm_prog_fail(ev[6]),
        .output_on_evt(ev[7]), .mem_update_done(ev[8]), .nvm_restore_load(ev[9]),
        .boot_restore_done(ev[10]), .boot_mismatch, .boot_parity_fail, .nvm_restore_data,
        .nvm_comm_image, .alert_assert, .smbalert_line_in, .comm_alert_req, .comm_summary,
        .other_summary);
    cms_host_model i_host (.core_clk, .reg_cmd, .reg_wr, .reg_wlen, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_rvalid);

    always #5 core_clk = ~core_clk;

    ////////////////////////////////////////
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // run takes under two hundred cycles, ceiling well above it
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pulse(input logic [10:0] m);
        @(negedge core_clk);
        ev = m;
        @(negedge core_clk);
        ev = 11'h000;
    endtask

    task automatic rdchk(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_host.rd(cmd, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask

    task automatic clr();
        i_host.wr(CMD_CLEAR_FAULTS, LEN_SEND_BYTE, 8'h00);
    endtask

    ////////////////////////////////////////
    task automatic t_reset();
        rdchk(CMD_COMM_STATUS, 8'h00);
        rdchk(CMD_FIRST_ALERT, 8'h00);
        chk({6'h00, comm_summary, other_summary}, 8'h00);
    endtask

    task automatic t_comm();
        int pos[4] = '{7, 6, 5, 1};
        for (int i = 0; i < 4; i++) begin
            pulse(11'(1 << i));
            rdchk(CMD_COMM_STATUS, 8'(1 << pos[i]));
            chk({7'h00, comm_summary}, 8'h01);
            i_host.wr(CMD_COMM_STATUS, LEN_WRITE_BYTE, 8'(1 << pos[i]));
            rdchk(CMD_COMM_STATUS, 8'h00);
            chk({7'h00, comm_summary}, 8'h00);
        end
    endtask

    task automatic t_clear();
        logic [7:0] d;
        logic       v;
        pulse(11'h005);
        i_host.wr(CMD_COMM_STATUS, LEN_WRITE_BYTE, 8'h0d);
        i_host.wr(CMD_COMM_STATUS, LEN_WRITE_BYTE, 8'h00);
        rdchk(CMD_COMM_STATUS, 8'ha0);
        clr();
        rdchk(CMD_COMM_STATUS, 8'h00);
        pulse(11'h00a);
        pulse(11'h080);
        rdchk(CMD_COMM_STATUS, 8'h00);
        i_host.wr(CMD_COMM_STATUS, LEN_SEND_BYTE, 8'h00);
        rdchk(CMD_COMM_STATUS, 8'h40);
        i_host.rd(8'h7d, d, v);
        chk({7'h00, v}, 8'h00);
        chk({7'h00, reg_claim}, 8'h00);
        i_host.rd(CMD_FIRST_ALERT, d, v);
        chk({7'h00, reg_claim}, 8'h01);
        clr();
    endtask

    task automatic t_mem();
        for (int k = 4; k < 7; k++) begin
            pulse(11'(1 << k));
            rdchk(CMD_COMM_STATUS, 8'h10);
            i_host.wr(CMD_COMM_STATUS, LEN_WRITE_BYTE, 8'h10);
            clr();
            pulse(11'h080);
            rdchk(CMD_COMM_STATUS, 8'h10);
            pulse(11'h100);
            i_host.wr(CMD_COMM_STATUS, LEN_WRITE_BYTE, 8'h10);
            rdchk(CMD_COMM_STATUS, 8'h00);
        end
        for (int j = 0; j < 3; j++) begin
            {boot_parity_fail, boot_mismatch} = 2'(j);
            pulse(11'h400);
            rdchk(CMD_COMM_STATUS, (j == 0) ? 8'h00 : 8'h10);
            pulse(11'h100);
            pulse(11'h080);
        end
        {boot_parity_fail, boot_mismatch} = 2'h0;
        nvm_restore_data = 8'hff;
        pulse(11'h200);
        chk(nvm_comm_image, 8'hf2);
        nvm_restore_data = 8'h00;
        pulse(11'h100);
        clr();
        chk(nvm_comm_image, 8'h00);
    endtask

    task automatic t_first();
        @(negedge core_clk);
        alert_assert = 1'b1;
        rdchk(CMD_FIRST_ALERT, 8'h01);
        chk({6'h00, other_summary, comm_alert_req}, 8'h02);
        i_host.wr(CMD_FIRST_ALERT, LEN_WRITE_BYTE, 8'hfe);
        rdchk(CMD_FIRST_ALERT, 8'h01);
        i_host.wr(CMD_FIRST_ALERT, LEN_WRITE_BYTE, 8'h01);
        rdchk(CMD_FIRST_ALERT, 8'h00);
        chk({7'h00, other_summary}, 8'h00);
        alert_assert = 1'b0;
        smbalert_line_in = 1'b0;
        repeat (4) @(negedge core_clk);
        alert_assert = 1'b1;
        rdchk(CMD_FIRST_ALERT, 8'h00);
        alert_assert = 1'b0;
        smbalert_line_in = 1'b1;
    endtask

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        ev = 11'h000;
        boot_mismatch = 1'b0;
        boot_parity_fail = 1'b0;
        nvm_restore_data = 8'h00;
        alert_assert = 1'b0;
        smbalert_line_in = 1'b1;
        mismatches = 0;
        cmp_count = 0;
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_comm();
        t_clear();
        t_mem();
        t_first();
        finish_test();
    end
endmodule

bind cms_status_flags cms_status_flags_monitor i_mon (.core_clk, .rst_n, .reg_cmd, .reg_wr,
    .reg_wlen, .reg_wdata, .reg_rd, .reg_claim, .reg_rvalid, .bad_command_evt, .bad_data_evt,
    .pec_fail_evt, .other_comm_evt, .store_parity_fail, .restore_parity_fail, .nvm_prog_fail,
    .nvm_restore_load, .alert_assert, .nvm_comm_image, .comm_alert_req, .comm_summary,
    .other_summary);
